//--- inc/drfu_pkg.sv
/*
 * Shared constants and types for the DRAM refresh unit and the external
 * DRAM controller: register indexes, field positions, reset values and
 * the processor bus states.
 * Assumes one clock domain; one clk_in cycle stands for one processor clock.
 */
package drfu_pkg;
   // Register indexes: three contiguous locations
   localparam logic [1:0] DRFU_IDX_BASE = 2'h0;
   localparam logic [1:0] DRFU_IDX_INTERVAL = 2'h1;
   localparam logic [1:0] DRFU_IDX_CONTROL = 2'h2;

   // Field positions and widths
   localparam int DRFU_ENABLE_BIT = 15;
   localparam int DRFU_CNT_W = 9;
   localparam int DRFU_BASE_W = 7;
   localparam int DRFU_ADDR_W = 20;
   localparam int DRFU_REG_W = 16;

   // Values after reset, and the counter's step of one
   localparam logic [8:0] DRFU_CNT_RST = 9'h000;
   localparam logic [8:0] DRFU_INTERVAL_RST = 9'h000;
   localparam logic [6:0] DRFU_BASE_RST = 7'h00;
   localparam logic [8:0] DRFU_ROW_RST = 9'h000;
   localparam logic [8:0] DRFU_CNT_ONE = 9'h001;

   // Fixed refresh address fields
   localparam logic [2:0] DRFU_ZERO_BITS = 3'h0;
   localparam logic DRFU_BIT_ZERO = 1'b1;

   // Data bus version: 1 = 16-bit bus (byte-high enable), 0 = 8-bit (refresh pin)
   localparam logic DRFU_WIDE_BUS = 1'b1;

   // Processor bus states, one clock each
   typedef enum logic [2:0] {
      DRFU_TI,
      DRFU_T1,
      DRFU_T2,
      DRFU_T3,
      DRFU_TW,
      DRFU_T4
   } drfu_bus_state_t;
endpackage : drfu_pkg

//--- inc/drfu_bus_if.sv
/*
 * Processor bus between the refresh-capable processor end and the external
 * DRAM controller end.
 * Assumes both ends run on the same clk_in; no clocking block.
 */
`timescale 1ns/1ps
interface drfu_bus_if;
   import drfu_pkg::*;
   logic [19:0] addr;
   logic byte_high_enable_n; // Refresh indicator pin on the 8-bit version
   logic rd_n;
   drfu_bus_state_t bus_state;
   logic ready;

   modport dev (
      output addr,
      output byte_high_enable_n,
      output rd_n,
      output bus_state,
      input ready
   );

   modport ctl (
      input addr,
      input byte_high_enable_n,
      input rd_n,
      input bus_state,
      output ready
   );
endinterface : drfu_bus_if

//--- core/drfu_row_lfsr.sv
/*
 * Nine-bit feedback shift counter for refresh row addresses.
 * Assumes step_in is a one-cycle pulse from the refresh engine.
 */
`timescale 1ns/1ps
module drfu_row_lfsr
   import drfu_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic step_in,
   output logic [8:0] row_out
);
   logic [8:0] row_reg;
   logic fb;

   // Maximal taps plus an all-zero patch, so all 512 values are visited
   assign fb = row_reg[8] ^ row_reg[4] ^ (row_reg[7:0] == 8'h00);

   // Row advances only on a completed refresh cycle
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         row_reg <= DRFU_ROW_RST;
      end else if (step_in) begin
         row_reg <= {row_reg[7:0], fb};
      end
   end

   assign row_out = row_reg;
endmodule : drfu_row_lfsr

//--- core/drfu_refresh_unit.sv
/*
 * Processor end: refresh interval counter, refresh registers, row counter
 * and a bus cycle engine that runs CPU reads and refresh dummy reads,
 * with hold arbitration against an external master.
 * Assumes the register port is driven by the processor's peripheral
 * control block and CPU read requests wait for cpu_done_out.
 */
`timescale 1ns/1ps
// Function
// - Refresh address 19:13 from base register
// - Refresh address 12:10 driven zero
// - Row bits from shift counter, bit0 high
// - Row counter visits all 512 values
// - Controller never routes bit0 to rows
// - Refresh cycle signals like ordinary read
// - 16-bit: byte-high and bit0 high
// - 8-bit: indicator low, bit0 high
// - Controller: row, strobe, column, strobe
// - Row strobe T2, column mux, column strobe T3
// - Column strobe optional on refresh
// - Strobes held through waits, released at T4
// - Base register places refresh on 8K
// - Row wrap never carries into base
// - Down-counter each clock, request at one
// - Enable bit readable, writable, resets zero
// - Low nine bits show live count
// - Disable clears the down-counter
// - Software writes zeros to reserved bits
// - Three contiguous register locations
// - Row advances after completed refresh cycle
// - Requests not queued, row kept
// - Refresh during hold drops acknowledge first
module drfu_refresh_unit
   import drfu_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Peripheral register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [1:0] reg_idx_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   // CPU memory read requests
   input wire logic cpu_req_in,
   input wire logic [19:0] cpu_addr_in,
   output logic cpu_done_out,
   // Bus hold arbitration
   input wire logic hold_req_in,
   output logic hold_acknowledge_out,
   // Status
   output logic refresh_pending_out,
   drfu_bus_if.dev bus
);
   typedef enum logic [1:0] {
      DRFU_OWN_NONE,
      DRFU_OWN_CPU,
      DRFU_OWN_REFRESH_INDICATOR_N
   } drfu_owner_t;

   logic [6:0] base_reg;
   logic [8:0] interval_reg;
   logic enable_reg;
   logic [8:0] count_reg;
   logic pending_reg;
   logic [15:0] rdata_reg;
   drfu_bus_state_t state_reg;
   drfu_owner_t owner_reg;
   logic hold_acknowledge_reg;
   logic [19:0] addr_reg;
   logic bhe_reg;
   logic rd_n_reg;
   logic cpu_done_reg;
   logic [8:0] row;
   logic tick;
   logic refresh_indicator_n_done;
   logic bus_free;
   logic [19:0] refresh_indicator_n_addr;
   logic ctl_wr;

   assign ctl_wr = reg_wr_in && (reg_idx_in == DRFU_IDX_CONTROL);
   // Refresh request fires as the count passes one
   assign tick = enable_reg && (count_reg == DRFU_CNT_ONE);
   assign refresh_indicator_n_done = (state_reg == DRFU_T4) && (owner_reg == DRFU_OWN_REFRESH_INDICATOR_N);
   assign bus_free = (state_reg == DRFU_TI) && !hold_acknowledge_reg;

   // Refresh address: base, zero bits, row, bit0 forced high
   assign refresh_indicator_n_addr = {base_reg, DRFU_ZERO_BITS, row, DRFU_BIT_ZERO};

   drfu_row_lfsr u_row (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .step_in(refresh_indicator_n_done),
      .row_out(row)
   );

   // Base and interval registers; the row counter never touches base
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         base_reg <= DRFU_BASE_RST;
         interval_reg <= DRFU_INTERVAL_RST;
      end else if (reg_wr_in) begin
         if (reg_idx_in == DRFU_IDX_BASE) begin
            base_reg <= reg_wdata_in[DRFU_BASE_W-1:0];
         end
         if (reg_idx_in == DRFU_IDX_INTERVAL) begin
            interval_reg <= reg_wdata_in[DRFU_CNT_W-1:0];
         end
      end
   end

   // Enable bit, writable at any time
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         enable_reg <= 1'b0;
      end else if (ctl_wr) begin
         enable_reg <= reg_wdata_in[DRFU_ENABLE_BIT];
      end
   end

   // Down-counter runs regardless of bus traffic so spacing stays exact
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         count_reg <= DRFU_CNT_RST;
      end else if (!enable_reg || (ctl_wr && !reg_wdata_in[DRFU_ENABLE_BIT])) begin
         count_reg <= DRFU_CNT_RST;
      end else if (count_reg == DRFU_CNT_RST || tick) begin
         count_reg <= interval_reg;
      end else begin
         count_reg <= count_reg - DRFU_CNT_ONE;
      end
   end

   // Single pending flag: a new tick simply keeps it set, set beats clear
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pending_reg <= 1'b0;
      end else if (tick) begin
         pending_reg <= 1'b1;
      end else if (refresh_indicator_n_done) begin
         pending_reg <= 1'b0;
      end
   end

   // Register read-back; reserved bits read zero
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_idx_in)
            DRFU_IDX_BASE: rdata_reg <= {9'h000, base_reg};
            DRFU_IDX_INTERVAL: rdata_reg <= {7'h00, interval_reg};
            DRFU_IDX_CONTROL: rdata_reg <= {enable_reg, 6'h00, count_reg};
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end

   // Hold acknowledge: dropped when refresh is pending, granted only
   // between cycles, so a hold during refresh waits for T4
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hold_acknowledge_reg <= 1'b0;
      end else if (hold_acknowledge_reg) begin
         if (!hold_req_in || pending_reg || tick) begin
            hold_acknowledge_reg <= 1'b0;
         end
      end else if (hold_req_in && !pending_reg && !tick && state_reg == DRFU_TI) begin
         hold_acknowledge_reg <= 1'b1;
      end
   end

   // Bus cycle engine; refresh outranks CPU, and waits for hold removal
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= DRFU_TI;
         owner_reg <= DRFU_OWN_NONE;
      end else begin
         case (state_reg)
            DRFU_TI: begin
               if (bus_free && pending_reg && !hold_req_in) begin
                  state_reg <= DRFU_T1;
                  owner_reg <= DRFU_OWN_REFRESH_INDICATOR_N;
               end else if (bus_free && !hold_req_in && cpu_req_in && !cpu_done_reg) begin
                  state_reg <= DRFU_T1;
                  owner_reg <= DRFU_OWN_CPU;
               end
            end
            DRFU_T1: state_reg <= DRFU_T2;
            DRFU_T2: state_reg <= DRFU_T3;
            DRFU_T3: state_reg <= bus.ready ? DRFU_T4 : DRFU_TW;
            DRFU_TW: state_reg <= bus.ready ? DRFU_T4 : DRFU_TW;
            DRFU_T4: begin
               state_reg <= DRFU_TI;
               owner_reg <= DRFU_OWN_NONE;
            end
            default: begin
               state_reg <= DRFU_TI;
               owner_reg <= DRFU_OWN_NONE;
            end
         endcase
      end
   end

   // Address and identification pins, latched at cycle start; refresh
   // uses the same read timing, only the identification pins differ
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         addr_reg <= 20'h00000;
         bhe_reg <= 1'b1;
      end else if (state_reg == DRFU_TI && bus_free && !hold_req_in) begin
         if (pending_reg) begin
            addr_reg <= refresh_indicator_n_addr;
            bhe_reg <= DRFU_WIDE_BUS ? 1'b1 : 1'b0;
         end else if (cpu_req_in && !cpu_done_reg) begin
            addr_reg <= cpu_addr_in;
            bhe_reg <= DRFU_WIDE_BUS ? 1'b0 : 1'b1; // Word read / indicator idle
         end
      end else if (state_reg == DRFU_T4) begin
         bhe_reg <= 1'b1; // Idle level on both versions
      end
   end

   // Read strobe from T2 until T4, same for both cycle kinds
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rd_n_reg <= 1'b1;
      end else if (state_reg == DRFU_T1) begin
         rd_n_reg <= 1'b0;
      end else if (state_reg == DRFU_T4) begin
         rd_n_reg <= 1'b1;
      end
   end

   // CPU completion pulse
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cpu_done_reg <= 1'b0;
      end else begin
         cpu_done_reg <= (state_reg == DRFU_T4) && (owner_reg == DRFU_OWN_CPU);
      end
   end

   assign bus.addr = addr_reg;
   assign bus.byte_high_enable_n = bhe_reg;
   assign bus.rd_n = rd_n_reg;
   assign bus.bus_state = state_reg;
   assign reg_rdata_out = rdata_reg;
   assign cpu_done_out = cpu_done_reg;
   assign hold_acknowledge_out = hold_acknowledge_reg;
   assign refresh_pending_out = pending_reg;
endmodule : drfu_refresh_unit

//--- core/drfu_dram_ctrl.sv
/*
 * External DRAM controller end: decodes processor bus states into row and
 * column strobes and a multiplexed address.
 * Assumes DRAM sits on the whole bus; row from address 9:1, column from 18:10.
 */
`timescale 1ns/1ps
module drfu_dram_ctrl
   import drfu_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic dram_ready_in,
   input wire logic cas_on_refresh_in,
   output logic [8:0] dram_addr_out,
   output logic ras_n_out,
   output logic cas_n_out,
   output logic refresh_seen_out,
   drfu_bus_if.ctl bus
);
   logic ras_n_reg;
   logic cas_n_reg;
   logic refresh_indicator_n_reg;
   logic [8:0] addr_reg;
   logic is_refresh_indicator_n;
   logic active;
   logic strobe_phase;

   // Refresh cycle: bit0 high plus identification pin level
   assign is_refresh_indicator_n = bus.addr[0] && (DRFU_WIDE_BUS ? bus.byte_high_enable_n
                                                  : !bus.byte_high_enable_n);
   assign active = (bus.bus_state != DRFU_TI);
   assign strobe_phase = (bus.bus_state == DRFU_T3) || (bus.bus_state == DRFU_TW);

   // Row strobe after T2, held through waits, dropped after T4
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ras_n_reg <= 1'b1;
      end else begin
         ras_n_reg <= !((bus.bus_state == DRFU_T2) || strobe_phase);
      end
   end

   // Column strobe after T3; refresh only when asked for
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cas_n_reg <= 1'b1;
      end else begin
         cas_n_reg <= !(strobe_phase && (!is_refresh_indicator_n || cas_on_refresh_in));
      end
   end

   // Multiplexed address: column from T2 on, row again after T4;
   // bit0 never reaches the row pins
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         addr_reg <= 9'h000;
      end else if (active && bus.bus_state != DRFU_T1 && bus.bus_state != DRFU_T4) begin
         addr_reg <= bus.addr[18:10];
      end else begin
         addr_reg <= bus.addr[9:1];
      end
   end

   // Refresh flag per cycle
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         refresh_indicator_n_reg <= 1'b0;
      end else begin
         refresh_indicator_n_reg <= active && is_refresh_indicator_n;
      end
   end

   assign bus.ready = dram_ready_in;
   assign dram_addr_out = addr_reg;
   assign ras_n_out = ras_n_reg;
   assign cas_n_out = cas_n_reg;
   assign refresh_seen_out = refresh_indicator_n_reg;
endmodule : drfu_dram_ctrl

//--- test/drfu_assertions.sv
/* Bus protocol checks on the processor bus between the two ends.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module drfu_assertions
   import drfu_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [19:0] addr,
   input wire logic byte_high_enable_n,
   input wire logic rd_n,
   input wire drfu_bus_state_t bus_state,
   input wire logic ready
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   rst_idle_a: assert property (disable iff (1'b0) sys_rst_in |=>
      bus_state == DRFU_TI && rd_n && byte_high_enable_n) else $error("bus busy after reset");
   rf_zero_a: assert property (bus_state == DRFU_T1 && byte_high_enable_n && addr[0]
      |-> addr[12:10] == DRFU_ZERO_BITS) else $error("refresh address 12:10 not zero");
   state_seq_a: assert property (bus_state == DRFU_T1 |=>
      bus_state == DRFU_T2 ##1 bus_state == DRFU_T3) else $error("bus state order broken");
   wait_st_a: assert property ((bus_state inside {DRFU_T3, DRFU_TW}) && !ready
      |=> bus_state == DRFU_TW) else $error("wait state not inserted");
   cycle_end_a: assert property ((bus_state inside {DRFU_T3, DRFU_TW}) && ready
      |=> bus_state == DRFU_T4 ##1 bus_state == DRFU_TI) else $error("cycle end wrong");
   addr_hold_a: assert property ((bus_state inside {DRFU_T2, DRFU_T3, DRFU_TW, DRFU_T4})
      |-> $stable(addr)) else $error("address moved inside bus cycle");
   rd_strobe_a: assert property (rd_n == (bus_state inside {DRFU_TI, DRFU_T1}))
      else $error("read strobe out of place");
   bhe_idle_a: assert property (bus_state == DRFU_TI |-> byte_high_enable_n)
      else $error("byte high enable active when idle");
   cyc_len_a: assert property (bus_state == DRFU_T1 |-> ##[4:200] bus_state == DRFU_TI)
      else $error("bus cycle never ends");
endmodule : drfu_assertions

//--- test/tb_top.sv
/* Self-checking bench: processor end and DRAM controller end joined by
   the bus interface. Assumes the shared package and a 125 MHz clock. */
`timescale 1ns/1ps
module tb_top;
   import drfu_pkg::*;
   logic clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic reg_wr = 1'h0, reg_rd = 1'h0, cpu_req = 1'h0, hold_req = 1'h0, rdy = 1'h1;
   logic cas_rf = 1'h0, rd_d = 1'h0, rnd_on = 1'h0, gap_on = 1'h0;
   logic cpu_done, hold_acknowledge, pend, ras_n, cas_n, rf_seen;
   logic [1:0] idx = 2'h0;
   logic [15:0] wdata = 16'h0000, rdata, m;
   logic [19:0] cpu_addr = 20'h00000, a;
   logic [8:0] dram_addr;
   logic [6:0] base_v = 7'h00;
   logic seen [512];
   logic [15:0] exp_q[$], msk_q[$];
   drfu_bus_state_t st;
   int fails = 0, checked = 0, seed = 41, n_rf = 0, last_t = -1, cyc = 0, i, k;

   drfu_bus_if u_drfu_bus_if ();
   assign st = u_drfu_bus_if.bus_state;
   assign a = u_drfu_bus_if.addr;

   drfu_refresh_unit u_drfu_refresh_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_idx_in(idx), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .cpu_req_in(cpu_req), .cpu_addr_in(cpu_addr),
      .cpu_done_out(cpu_done), .hold_req_in(hold_req), .hold_acknowledge_out(hold_acknowledge),
      .refresh_pending_out(pend), .bus(u_drfu_bus_if));
   drfu_dram_ctrl u_drfu_dram_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .dram_ready_in(rdy), .cas_on_refresh_in(cas_rf), .dram_addr_out(dram_addr),
      .ras_n_out(ras_n), .cas_n_out(cas_n), .refresh_seen_out(rf_seen), .bus(u_drfu_bus_if));
   drfu_assertions u_drfu_assertions (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr(a),
      .byte_high_enable_n(u_drfu_bus_if.byte_high_enable_n), .rd_n(u_drfu_bus_if.rd_n),
      .bus_state(st), .ready(u_drfu_bus_if.ready));

   // 8 ns period
   initial forever #4 clk_in = ~clk_in;

   // Cycle count; random wait states stand in for slow DRAM
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      rdy <= rnd_on ? (($random(seed) & 3) != 0) : 1'h1;
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   // Register read data against the queued note
   task automatic chk_rdata(input logic [15:0] e, input logic [15:0] s);
      chk("rdata", {16'h0000, e}, {16'h0000, s});
   endtask : chk_rdata

   // Single-bit status and handshake outputs
   task automatic chk_flag(input string what, input logic e, input logic s);
      chk(what, {31'h0, e}, {31'h0, s});
   endtask : chk_flag

   task automatic tally_and_finish;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         $display("Error wait expected event seen timeout");
         fails++;
         tally_and_finish();
      end
   endtask : limit

   // Idle cycle after each strobe so no signal is set twice in one step
   task automatic wr(input logic [1:0] ix, input logic [15:0] d);
      idx <= ix;
      wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_in);
      reg_wr <= 1'h0;
      @(posedge clk_in);
   endtask : wr

   task automatic rd(input logic [1:0] ix, input logic [15:0] e, input logic [15:0] mk = 16'hFFFF);
      exp_q.push_back(e);
      msk_q.push_back(mk);
      idx <= ix;
      reg_rd <= 1'h1;
      @(posedge clk_in);
      reg_rd <= 1'h0;
      @(posedge clk_in);
   endtask : rd

   // Read data is valid the cycle after the strobe
   always @(posedge clk_in) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         m = msk_q.pop_front();
         chk_rdata(exp_q.pop_front() & m, rdata & m);
      end
   end

   // Address fields, strobes and multiplexer per bus state
   always @(posedge clk_in) begin
      if (st == DRFU_T2 && a[0]) begin
         chk("rf_upper", {base_v, 3'h0}, a[19:10]);
         chk("bhe_n", 1'h1, u_drfu_bus_if.byte_high_enable_n);
         chk("row_new", 1'h0, seen[a[9:1]]);
         seen[a[9:1]] = 1'h1;
         n_rf++;
         if (n_rf % 512 == 0) seen = '{default: 1'h0};
         if (gap_on && last_t >= 0) chk("gap", 16, cyc - last_t);
         last_t = cyc;
      end
      if (st == DRFU_T2 && !a[0]) chk("cpu_addr", cpu_addr, a);
      if (st == DRFU_T2) chk("row_mux", a[9:1], dram_addr);
      if (st == DRFU_T3) chk("col_mux", a[18:10], dram_addr);
      if (st == DRFU_T3 && a[0]) chk("rf_seen", 1'h1, rf_seen);
      if (st == DRFU_T4) chk("ras_n", 1'h0, ras_n);
      if (st == DRFU_T4) chk("cas_n", a[0] && !cas_rf, cas_n);
   end

   // Main sequence
   initial begin
      seen = '{default: 1'h0};
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      @(posedge clk_in);
      for (i = 0; i < 4; i++) rd(i[1:0], 16'h0000);
      base_v = 7'h55;
      wr(2'h0, {9'h000, base_v});
      wr(2'h1, 16'h0010);
      rd(2'h0, {9'h000, base_v});
      rd(2'h1, 16'h0010);
      gap_on <= 1'h1;
      wr(2'h2, 16'h81FF);
      rd(2'h2, 16'h8000, 16'hFE00);
      for (k = 0; k < 300 && n_rf < 6; k++) @(posedge clk_in);
      limit(k, 300);
      gap_on <= 1'h0;
      // Refresh wanted while another master holds the bus
      hold_req <= 1'h1;
      for (k = 0; k < 40 && !hold_acknowledge; k++) @(posedge clk_in);
      limit(k, 40);
      for (k = 0; k < 40 && !pend; k++) @(posedge clk_in);
      limit(k, 40);
      repeat (2) @(posedge clk_in);
      chk_flag("hold_acknowledge", 1'h0, hold_acknowledge);
      chk_flag("pend", 1'h1, pend);
      chk("held", DRFU_TI, st);
      hold_req <= 1'h0;
      // Interval of one floods requests; only one stays pending
      wr(2'h2, 16'h0000);
      rd(2'h2, 16'h0000);
      wr(2'h1, 16'h0001);
      wr(2'h2, 16'h8000);
      rd(2'h2, 16'h8001);
      rnd_on <= 1'h1;
      for (k = 0; k < 20000 && n_rf < 600; k++) begin
         @(posedge clk_in);
         if (st == DRFU_TI) cas_rf <= 1'($random(seed));
      end
      limit(k, 20000);
      // CPU reads with refresh off
      wr(2'h2, 16'h0000);
      for (i = 0; i < 4; i++) begin
         cpu_addr <= 20'($random(seed)) & 20'hFFFFE;
         cpu_req <= 1'h1;
         @(posedge clk_in);
         for (k = 0; k < 60 && !(st == DRFU_T4 && !a[0]); k++) @(posedge clk_in);
         limit(k, 60);
         cpu_req <= 1'h0;
         @(posedge clk_in);
         chk_flag("cpu_done", 1'h1, cpu_done);
      end
      tally_and_finish();
   end
endmodule : tb_top
